//--- hw/first_set_enc.sv
// Purpose: Finds the lowest-numbered set bit of a request vector
// Assumes: Purely combinational, used inside the clocked controller
// Notes: Lowest index wins, matching the fixed service order
`default_nettype none
module first_set_enc #(
  parameter int WIDTH = 15,
  parameter int IDX_W = 4
) (
  input wire logic [WIDTH-1:0] vec_i,
  output logic found_o,
  output logic [IDX_W-1:0] index_o
);
  initial
  begin
    if (WIDTH < 1 || (1 << IDX_W) < WIDTH)
      $error("first_set_enc: index too narrow for width");
  end

  // Scan from the top so the lowest set bit is left last
  always_comb
  begin
    found_o = 1'b0;
    index_o = '0;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (vec_i[i])
      begin
        found_o = 1'b1;
        index_o = IDX_W'(i);
      end
    end
  end
endmodule
`default_nettype wire

//--- hw/irq_enable_priority_regs.sv
// Purpose: Interrupt enable and priority registers with two-level arbitration
// Assumes: Core writes bytes or single bits over the special-function port
// Notes: Extended sources have no priority register here and rank as low level
`default_nettype none
module irq_enable_priority_regs #(
  parameter int NUM_SRC = irq_cfg_pkg::NUM_SOURCES
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire irq_cfg_pkg::sfr_req_t sfr_i,
  input wire irq_cfg_pkg::irq_flags_t flags_i,
  input wire logic vec_ack_i,
  input wire logic reti_i,
  output logic [7:0] sfr_rdata_o,
  output logic sfr_hit_o,
  output logic irq_req_o,
  output logic irq_high_o,
  output logic [irq_cfg_pkg::INDEX_W-1:0] irq_index_o,
  output logic [NUM_SRC-1:0] irq_pending_o,
  output logic svc_low_o,
  output logic svc_high_o
);
  initial
  begin
    if (NUM_SRC != irq_cfg_pkg::NUM_SOURCES)
      $error("irq_enable_priority_regs: source count is fixed by the register map");
  end

  irq_cfg_pkg::ctl_state_t state;
  irq_cfg_pkg::ctl_state_t next_state;
  logic [NUM_SRC-1:0] raw_pend;
  logic [NUM_SRC-1:0] src_mask;
  logic [NUM_SRC-1:0] src_level;
  logic [NUM_SRC-1:0] gated;
  logic [NUM_SRC-1:0] high_cand;
  logic [NUM_SRC-1:0] low_cand;
  logic high_found;
  logic low_found;
  logic [irq_cfg_pkg::INDEX_W-1:0] high_idx;
  logic [irq_cfg_pkg::INDEX_W-1:0] low_idx;
  logic [7:0] ie_bits;
  logic [7:0] ip_bits;
  logic [7:0] eie_bits;
  logic hit_ie_byte;
  logic hit_ip_byte;
  logic hit_eie_byte;
  logic hit_ie_bit;
  logic hit_ip_bit;
  // Width of the bit-number field inside a bit address
  localparam int BIT_SEL_W_LOCAL = irq_cfg_pkg::BIT_SEL_W;
  logic [BIT_SEL_W_LOCAL-1:0] bit_sel;

  // Raw pending flags in fixed service order
  always_comb
  begin
    raw_pend[0] = flags_i.ext_irq0_pin;
    raw_pend[1] = flags_i.timer0_overflow_flag;
    raw_pend[2] = flags_i.ext_irq1_pin;
    raw_pend[3] = flags_i.timer1_overflow_flag;
    raw_pend[4] = flags_i.uart_flag;
    raw_pend[5] = flags_i.timer2_low_overflow_flag | flags_i.timer2_high_overflow_flag;
    raw_pend[6] = flags_i.spi_flag;
    raw_pend[7] = flags_i.twowire_flag;
    raw_pend[8] = flags_i.port_match_flag;
    raw_pend[9] = flags_i.adc_window_flag;
    raw_pend[10] = flags_i.adc_done_flag;
    raw_pend[11] = flags_i.counter_array_flag;
    raw_pend[12] = flags_i.comparator0_flag;
    raw_pend[13] = flags_i.comparator1_flag;
    raw_pend[14] = flags_i.timer3_flag;
  end

  // Per-source mask bits from both enable registers
  always_comb
  begin
    src_mask[0] = state.ie.ext_irq0_mask;
    src_mask[1] = state.ie.timer0_irq_mask;
    src_mask[2] = state.ie.ext_irq1_mask;
    src_mask[3] = state.ie.timer1_irq_mask;
    src_mask[4] = state.ie.uart_irq_mask;
    src_mask[5] = state.ie.timer2_irq_mask;
    src_mask[6] = state.ie.spi_irq_mask;
    src_mask[7] = state.eie.twowire_irq_mask;
    src_mask[8] = state.eie.port_match_irq_mask;
    src_mask[9] = state.eie.adc_window_irq_mask;
    src_mask[10] = state.eie.adc_done_irq_mask;
    src_mask[11] = state.eie.counter_array_irq_mask;
    src_mask[12] = state.eie.comparator0_irq_mask;
    src_mask[13] = state.eie.comparator1_irq_mask;
    src_mask[14] = state.eie.timer3_irq_mask;
  end

  // Level of each source; extended sources rank low
  always_comb
  begin
    src_level = '0;
    src_level[0] = state.ip[0];
    src_level[1] = state.ip[1];
    src_level[2] = state.ip[2];
    src_level[3] = state.ip[3];
    src_level[4] = state.ip[4];
    src_level[5] = state.ip[5];
    src_level[6] = state.ip[6];
  end

  // Gate and masks decide what reaches arbitration
  always_comb
  begin
    if (state.ie.global_irq_gate)
      gated = raw_pend & src_mask;
    else
      gated = '0;
    high_cand = gated & src_level;
    low_cand = gated & ~src_level;
  end

  // Lowest order number wins within each level
  first_set_enc #(
    .WIDTH(NUM_SRC),
    .IDX_W(irq_cfg_pkg::INDEX_W)
  ) u_high_enc (
    .vec_i(high_cand),
    .found_o(high_found),
    .index_o(high_idx)
  );

  first_set_enc #(
    .WIDTH(NUM_SRC),
    .IDX_W(irq_cfg_pkg::INDEX_W)
  ) u_low_enc (
    .vec_i(low_cand),
    .found_o(low_found),
    .index_o(low_idx)
  );

  // Register images as software reads them
  always_comb
  begin
    ie_bits = state.ie;
    ip_bits = {1'b1, state.ip};
    eie_bits = state.eie;
  end

  // Address decode for byte and bit access
  always_comb
  begin
    bit_sel = sfr_i.bit_addr[BIT_SEL_W_LOCAL-1:0];
    hit_ie_byte = (sfr_i.addr == irq_cfg_pkg::ENABLE_MAIN_ADDR);
    hit_ip_byte = (sfr_i.addr == irq_cfg_pkg::PRIORITY_MAIN_ADDR);
    hit_eie_byte = (sfr_i.addr == irq_cfg_pkg::ENABLE_EXT_ADDR);
    hit_ie_bit = (sfr_i.bit_addr[7:BIT_SEL_W_LOCAL]
                  == irq_cfg_pkg::ENABLE_MAIN_ADDR[7:BIT_SEL_W_LOCAL]);
    hit_ip_bit = (sfr_i.bit_addr[7:BIT_SEL_W_LOCAL]
                  == irq_cfg_pkg::PRIORITY_MAIN_ADDR[7:BIT_SEL_W_LOCAL]);
  end

  // Next-state logic: writes, read capture, service tracking, arbitration
  always_comb
  begin
    logic [7:0] new_ie;
    logic [7:0] new_ip;
    logic svc_l;
    logic svc_h;
    new_ie = ie_bits;
    new_ip = ip_bits;
    svc_l = state.svc_low;
    svc_h = state.svc_high;
    next_state = state;

    // Byte writes
    if (sfr_i.byte_wr && hit_ie_byte)
      new_ie = sfr_i.wdata;
    if (sfr_i.byte_wr && hit_ip_byte)
      new_ip = sfr_i.wdata;
    if (sfr_i.byte_wr && hit_eie_byte)
      next_state.eie = sfr_i.wdata;

    // Single-bit writes; the extended register has no bit access
    if (sfr_i.bit_wr && hit_ie_bit)
      new_ie[bit_sel] = sfr_i.bit_val;
    if (sfr_i.bit_wr && hit_ip_bit)
      new_ip[bit_sel] = sfr_i.bit_val;

    next_state.ie = new_ie;
    next_state.ip = new_ip[6:0];

    // Read data is captured one edge after the strobe
    next_state.hit = 1'b0;
    next_state.rdata = irq_cfg_pkg::READ_UNMAPPED;
    if (sfr_i.rd)
    begin
      if (hit_ie_byte)
      begin
        next_state.hit = 1'b1;
        next_state.rdata = ie_bits;
      end
      else if (hit_ip_byte)
      begin
        next_state.hit = 1'b1;
        next_state.rdata = ip_bits;
      end
      else if (hit_eie_byte)
      begin
        next_state.hit = 1'b1;
        next_state.rdata = eie_bits;
      end
    end

    // Return from service closes the innermost level first
    if (reti_i)
    begin
      if (svc_h)
        svc_h = 1'b0;
      else
        svc_l = 1'b0;
    end

    // Core taking the vector opens service at the granted level
    if (vec_ack_i && state.req)
    begin
      if (state.hi)
        svc_h = 1'b1;
      else
        svc_l = 1'b1;
    end
    next_state.svc_low = svc_l;
    next_state.svc_high = svc_h;

    // High may interrupt low service; nothing interrupts high service
    next_state.req = 1'b0;
    next_state.hi = 1'b0;
    next_state.idx = '0;
    if (high_found && !svc_h)
    begin
      next_state.req = 1'b1;
      next_state.hi = 1'b1;
      next_state.idx = high_idx;
    end
    else if (low_found && !svc_h && !svc_l)
    begin
      next_state.req = 1'b1;
      next_state.idx = low_idx;
    end

    // Pending view ignores masks and gate
    next_state.pend = raw_pend;
  end

  // State register
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state.ie <= irq_cfg_pkg::ENABLE_MAIN_RESET;
      state.ip <= irq_cfg_pkg::PRIORITY_MAIN_RESET[6:0];
      state.eie <= irq_cfg_pkg::ENABLE_EXT_RESET;
      state.rdata <= irq_cfg_pkg::READ_UNMAPPED;
      state.hit <= 1'b0;
      state.req <= 1'b0;
      state.hi <= 1'b0;
      state.idx <= '0;
      state.svc_low <= 1'b0;
      state.svc_high <= 1'b0;
      state.pend <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  always_comb
  begin
    sfr_rdata_o = state.rdata;
    sfr_hit_o = state.hit;
    irq_req_o = state.req;
    irq_high_o = state.hi;
    irq_index_o = state.idx;
    irq_pending_o = state.pend;
    svc_low_o = state.svc_low;
    svc_high_o = state.svc_high;
  end
endmodule
`default_nettype wire

//--- include/irq_cfg_pkg.sv
// Purpose: Shared constants and types for the interrupt enable/priority block
// Assumes: 8-bit special-function register port, single system clock
// Notes: Field order in the packed structs follows register bit order, MSB first
`default_nettype none
package irq_cfg_pkg;
  // Special-function addresses
  localparam logic [7:0] ENABLE_MAIN_ADDR = 8'hA8;
  localparam logic [7:0] PRIORITY_MAIN_ADDR = 8'hB8;
  localparam logic [7:0] ENABLE_EXT_ADDR = 8'hE6;
  // Values after reset
  localparam logic [7:0] ENABLE_MAIN_RESET = 8'h00;
  localparam logic [7:0] PRIORITY_MAIN_RESET = 8'h80;
  localparam logic [7:0] ENABLE_EXT_RESET = 8'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  // Bit-address split: upper bits pick the register, lower bits the bit
  localparam int BIT_SEL_W = 3;
  localparam int GATE_BIT = 7;
  localparam int RESERVED_PRIO_BIT = 7;
  localparam int NUM_SOURCES = 15;
  localparam int INDEX_W = 4;

  // Main enable register layout
  typedef struct packed {
    logic global_irq_gate;
    logic spi_irq_mask;
    logic timer2_irq_mask;
    logic uart_irq_mask;
    logic timer1_irq_mask;
    logic ext_irq1_mask;
    logic timer0_irq_mask;
    logic ext_irq0_mask;
  } enable_main_t;

  // Extended enable register layout
  typedef struct packed {
    logic timer3_irq_mask;
    logic comparator1_irq_mask;
    logic comparator0_irq_mask;
    logic counter_array_irq_mask;
    logic adc_done_irq_mask;
    logic adc_window_irq_mask;
    logic port_match_irq_mask;
    logic twowire_irq_mask;
  } enable_ext_t;

  // Pending flags raised by the peripherals
  typedef struct packed {
    logic timer3_flag;
    logic comparator1_flag;
    logic comparator0_flag;
    logic counter_array_flag;
    logic adc_done_flag;
    logic adc_window_flag;
    logic port_match_flag;
    logic twowire_flag;
    logic spi_flag;
    logic timer2_high_overflow_flag;
    logic timer2_low_overflow_flag;
    logic uart_flag;
    logic timer1_overflow_flag;
    logic ext_irq1_pin;
    logic timer0_overflow_flag;
    logic ext_irq0_pin;
  } irq_flags_t;

  // Special-function register access from the core
  typedef struct packed {
    logic [7:0] addr;
    logic byte_wr;
    logic rd;
    logic [7:0] wdata;
    logic bit_wr;
    logic [7:0] bit_addr;
    logic bit_val;
  } sfr_req_t;

  // Whole state of the controller
  typedef struct packed {
    enable_main_t ie;
    logic [6:0] ip;
    enable_ext_t eie;
    logic [7:0] rdata;
    logic hit;
    logic req;
    logic hi;
    logic [INDEX_W-1:0] idx;
    logic svc_low;
    logic svc_high;
    logic [NUM_SOURCES-1:0] pend;
  } ctl_state_t;
endpackage
`default_nettype wire

//--- test/core_model.sv
// Purpose: Core side that takes offered vectors and returns from service
// Assumes: Acknowledge wait is set by the bench
// Notes: Never acknowledges twice for one offer
`default_nettype none
module core_model (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic irq_req_i,
  input wire logic ack_en_i,
  input wire logic [3:0] ack_wait_i,
  input wire logic reti_req_i,
  output logic vec_ack_o,
  output logic reti_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_cnt;
  // Takes an offer after the chosen wait, one pulse each
  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      wait_cnt <= 4'h0;
      vec_ack_o <= 1'b0;
      reti_o <= 1'b0;
    end
    else
    begin
      vec_ack_o <= 1'b0;
      reti_o <= reti_req_i;
      if (irq_req_i && ack_en_i && !vec_ack_o)
        if (wait_cnt == ack_wait_i)
        begin
          vec_ack_o <= 1'b1;
          wait_cnt <= 4'h0;
        end
        else
          wait_cnt <= wait_cnt + 4'h1;
      else
        wait_cnt <= 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- test/irq_regs_chk.sv
// Purpose: Port-level checks of the interrupt configuration block
// Assumes: One clock, flags held low while reset is applied
// Notes: Answers are registered one cycle after the cause
`default_nettype none
module irq_regs_chk #(parameter int NUM_SRC = 15) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire irq_cfg_pkg::sfr_req_t sfr_i,
  input wire irq_cfg_pkg::irq_flags_t flags_i,
  input wire logic vec_ack_i,
  input wire logic reti_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic sfr_hit_o,
  input wire logic irq_req_o,
  input wire logic irq_high_o,
  input wire logic [irq_cfg_pkg::INDEX_W-1:0] irq_index_o,
  input wire logic [NUM_SRC-1:0] irq_pending_o,
  input wire logic svc_low_o,
  input wire logic svc_high_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Read of a mapped register, and a vector taken by the core
  sequence s_map_rd;
    sfr_i.rd && (sfr_i.addr inside {8'hA8, 8'hB8, 8'hE6});
  endsequence
  sequence s_take;
    irq_req_o && vec_ack_i && !reti_i;
  endsequence
  property p_hit; s_map_rd |=> sfr_hit_o; endproperty
  a_hit: assert property (p_hit) else $error("mapped read gave no hit");
  property p_unmap; sfr_i.rd && !(sfr_i.addr inside {8'hA8, 8'hB8, 8'hE6}) |=> !sfr_hit_o && sfr_rdata_o == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read answered");
  property p_prio7; sfr_i.rd && sfr_i.addr == 8'hB8 |=> sfr_rdata_o[7]; endproperty
  a_prio7: assert property (p_prio7) else $error("priority bit 7 read low");
  property p_pend; 1'b1 |=> irq_pending_o[0] == $past(flags_i.ext_irq0_pin)
    && irq_pending_o[5] == $past(flags_i.timer2_low_overflow_flag | flags_i.timer2_high_overflow_flag);
  endproperty
  a_pend: assert property (p_pend) else $error("pending does not follow flags");
  property p_req_flag; irq_req_o |-> irq_pending_o[irq_index_o] || $past(irq_pending_o[irq_index_o]); endproperty
  a_req_flag: assert property (p_req_flag) else $error("request without pending flag");
  property p_low_svc; s_take ##0 !irq_high_o |=> svc_low_o; endproperty
  a_low_svc: assert property (p_low_svc) else $error("low vector not in service");
  property p_high_svc; s_take ##0 irq_high_o |=> svc_high_o; endproperty
  a_high_svc: assert property (p_high_svc) else $error("high vector not in service");
  property p_hi_hold; svc_high_o && $past(svc_high_o) |-> !irq_req_o; endproperty
  a_hi_hold: assert property (p_hi_hold) else $error("high service preempted");
  property p_lo_pre; svc_low_o && $past(svc_low_o) && irq_req_o |-> irq_high_o; endproperty
  a_lo_pre: assert property (p_lo_pre) else $error("low offered during low service");
  property p_reti; svc_high_o && reti_i && !vec_ack_i |=> !svc_high_o; endproperty
  a_reti: assert property (p_reti) else $error("return left high service");
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Purpose: Register and arbitration tests of the interrupt block
// Assumes: 20 MHz clock, reset held ten cycles
// Notes: Priority writes keep bit 7 set as software must
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  irq_cfg_pkg::sfr_req_t sfr = '0;
  irq_cfg_pkg::irq_flags_t flags = '0;
  logic ack_en = 1'b0;
  logic [3:0] ack_wait = 4'h0;
  logic reti_req = 1'b0;
  logic vec_ack, reti, hit, req, hi, s_lo, s_hi;
  logic [7:0] rdata;
  logic [3:0] idx;
  logic [14:0] pend;
  int bad_count = 0;
  int n_compared = 0;
  irq_enable_priority_regs #(.NUM_SRC(15)) dut (.ref_clk_i, .resetn_i, .sfr_i(sfr), .flags_i(flags),
    .vec_ack_i(vec_ack), .reti_i(reti), .sfr_rdata_o(rdata), .sfr_hit_o(hit), .irq_req_o(req),
    .irq_high_o(hi), .irq_index_o(idx), .irq_pending_o(pend), .svc_low_o(s_lo), .svc_high_o(s_hi));
  core_model partner (.ref_clk_i, .resetn_i, .irq_req_i(req), .ack_en_i(ack_en), .ack_wait_i(ack_wait),
    .reti_req_i(reti_req), .vec_ack_o(vec_ack), .reti_o(reti));
  // Clock source
  initial
  begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Register port cycles: strobe for one edge, then release
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    sfr <= '{addr: a, byte_wr: 1'b1, wdata: d, default: '0};
    @(posedge ref_clk_i);
    sfr <= '0;
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    @(posedge ref_clk_i);
    sfr <= '{bit_addr: a, bit_wr: 1'b1, bit_val: v, default: '0};
    @(posedge ref_clk_i);
    sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge ref_clk_i);
    sfr <= '{addr: a, rd: 1'b1, default: '0};
    @(posedge ref_clk_i);
    sfr <= '0;
    #1;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
    chk("hit", {15'h0000, h}, {15'h0000, hit});
  endtask
  task automatic setf(input logic [15:0] v, input logic en);
    @(posedge ref_clk_i);
    flags <= v;
    ack_en <= en;
    ack_wait <= 4'h2;
  endtask
  task automatic irq_chk(input logic r, input logic h, input logic [3:0] i);
    chk("irq", {10'h000, r, h, i}, {10'h000, req, r ? {hi, idx} : 5'h00});
  endtask
  task automatic wait_svc(input logic [1:0] e);
    int k;
    for (k = 0; k < 40 && {s_hi, s_lo} !== e; k++)
      tick(1);
    chk("svc", {14'h0000, e}, {14'h0000, s_hi, s_lo});
    if (k == 40)
      close_out();
  endtask
  task automatic ret;
    @(posedge ref_clk_i);
    reti_req <= 1'b1;
    @(posedge ref_clk_i);
    reti_req <= 1'b0;
  endtask
  // Main sequence
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    rd(8'hA8, 8'h00, 1'b1);
    rd(8'hB8, 8'h80, 1'b1);
    rd(8'hE6, 8'h00, 1'b1);
    rd(8'h55, 8'h00, 1'b0);
    wr(8'hA8, 8'h5A);
    wr(8'hB8, 8'hA5);
    wr(8'hE6, 8'hC3);
    bw(8'hA8, 1'b1);
    bw(8'hBD, 1'b0);
    bw(8'hE7, 1'b0);
    rd(8'hA8, 8'h5B, 1'b1);
    rd(8'hB8, 8'h85, 1'b1);
    rd(8'hE6, 8'hC3, 1'b1);
    wr(8'hB8, 8'h80);
    setf(16'hFFFF, 1'b0);
    tick(3);
    chk("pending", 16'h7FFF, {1'b0, pend});
    irq_chk(1'b0, 1'b0, 4'h0);
    for (int i = 0; i < 15; i++)
    begin
      wr(8'hE6, (i > 6) ? 8'h01 << (i - 7) : 8'h00);
      wr(8'hA8, 8'h80 | ((i < 7) ? 8'h01 << i : 8'h00));
      tick(3);
      irq_chk(1'b1, 1'b0, i[3:0]);
      wr(8'hA8, (i < 7) ? 8'h01 << i : 8'h00);
      tick(3);
      irq_chk(1'b0, 1'b0, 4'h0);
    end
    setf(16'h0040, 1'b0);
    wr(8'hA8, 8'hA0);
    tick(3);
    irq_chk(1'b1, 1'b0, 4'h5);
    setf(16'h0020, 1'b0);
    tick(3);
    irq_chk(1'b1, 1'b0, 4'h5);
    setf(16'hFFFF, 1'b0);
    wr(8'hE6, 8'hFF);
    wr(8'hA8, 8'hFF);
    for (int i = 0; i < 7; i++)
    begin
      wr(8'hB8, 8'h80 | (8'h01 << i));
      tick(3);
      irq_chk(1'b1, 1'b1, i[3:0]);
    end
    wr(8'hB8, 8'hE0);
    tick(3);
    irq_chk(1'b1, 1'b1, 4'h5);
    wr(8'hB8, 8'h80);
    tick(3);
    irq_chk(1'b1, 1'b0, 4'h0);
    wr(8'hB8, 8'hC2);
    setf(16'h0001, 1'b0);
    setf(16'h0001, 1'b1);
    wait_svc(2'b01);
    setf(16'h0081, 1'b1);
    wait_svc(2'b11);
    setf(16'h0083, 1'b1);
    tick(4);
    irq_chk(1'b0, 1'b0, 4'h0);
    setf(16'h0000, 1'b1);
    ret();
    wait_svc(2'b01);
    ret();
    wait_svc(2'b00);
    close_out();
  end
endmodule
bind irq_enable_priority_regs irq_regs_chk #(.NUM_SRC(NUM_SRC)) chk_i (.ref_clk_i, .resetn_i, .sfr_i, .flags_i,
  .vec_ack_i, .reti_i, .sfr_rdata_o, .sfr_hit_o, .irq_req_o, .irq_high_o, .irq_index_o, .irq_pending_o,
  .svc_low_o, .svc_high_o);
`default_nettype wire
